// File: include/sosc_pkg.sv
// Function
// (RQ1) Outputs on only when all conditions hold
// (RQ2) Outputs off on absence, low input, fault
// (RQ3) Self-test dropouts no longer than 0.3 ms
// (RQ4) Downstream tolerates dropouts, no own pulses
// (RQ5) Outputs active high, drive supply level
// (RQ6) Downstream never uses diagnosis for safety
// (RQ7) Ignore input low pulses up to 900 us
// (RQ8) Chain: first inputs high, others chained
// (RQ9) Unused feedback input held high
// (RQ10) Automatic feedback only on last sensor
// (RQ11) Start variant needs valid start pulse
// (RQ12) Valid start pulse lasts 30 ms to 5 s
// (RQ13) Diagnosis pulses follow yellow timing
// (RQ14) Ready: green steady, diagnosis and outputs high
// (RQ15) Inputs low: green blinks, outputs off
// (RQ16) Awaiting start: green flashes, outputs off
// (RQ17) Range edge: yellow blinks, outputs held
// (RQ18) Teach-in: yellow flashes, outputs off
// (RQ19) Fault: red blinks, diagnosis, outputs low
// (RQ20) Blink ratio 1:1, flash ratio 1:5
// (RQ21) Red pulse count encodes fault cause
// (RQ22) Teach-in: six red blinks, yellow after 10 s
// (RQ23) Not operational before 1000 ms readiness
// (RQ24) Counters sized for longest interval, 10 s
package sosc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned DROP_MAX_US = 300;
    localparam int unsigned DROP_CYC = DROP_MAX_US * 200;
    localparam int unsigned GLITCH_US = 900;
    localparam int unsigned GLITCH_CYC = GLITCH_US * 200;
    localparam int unsigned START_MIN_MS = 30;
    localparam int unsigned START_MIN_CYC = START_MIN_MS * 200_000;
    localparam int unsigned START_MAX_MS = 5000;
    localparam int unsigned START_MAX_CYC = START_MAX_MS * 200_000;
    localparam int unsigned READY_MS = 1000;
    localparam int unsigned READY_CYC = READY_MS * 200_000;
    localparam int unsigned TEACH_WAIT_MS = 10_000;
    localparam int unsigned TEACH_WAIT_CYC = TEACH_WAIT_MS * 200_000;
    localparam int unsigned TEST_PERIOD_MS = 10;
    localparam int unsigned TEST_PERIOD_CYC = TEST_PERIOD_MS * 200_000;
    localparam int unsigned SLOT_MS = 100;
    localparam int unsigned SLOT_CYC = SLOT_MS * 200_000;
    localparam int unsigned CNT_W = 32;

    // ----------------------------------------------------------------
    // Codes
    // ----------------------------------------------------------------
    localparam logic [2:0] PULSES_OUT = 3'h1;
    localparam logic [2:0] PULSES_IN = 3'h2;
    localparam logic [2:0] PULSES_FB = 3'h3;
    localparam logic [2:0] PULSES_WRONG = 3'h6;
    localparam logic [2:0] PULSES_TEACH = 3'h6;

    typedef enum logic [2:0] {
        ST_INIT, ST_IDLE, ST_INLOW, ST_WAITSTART, ST_ON, ST_TEACH, ST_FAULT
    } sosc_state_t;

    typedef struct packed {
        logic green;
        logic red;
        logic yellow;
    } sosc_led_t;

    typedef struct packed {
        logic out_fault;
        logic in_fault;
        logic fb_fault;
        logic wrong_actuator;
    } sosc_fault_t;

endpackage : sosc_pkg

// File: rtl/sosc_ctrl.sv
`timescale 1ns/1ps
module sosc_ctrl
    import sosc_pkg::*;
#(
    parameter int unsigned READY_CYCLES = READY_CYC,
    parameter int unsigned GLITCH_CYCLES = GLITCH_CYC,
    parameter int unsigned START_MIN_CYCLES = START_MIN_CYC,
    parameter int unsigned START_MAX_CYCLES = START_MAX_CYC,
    parameter int unsigned TEACH_CYCLES = TEACH_WAIT_CYC,
    parameter int unsigned TEST_CYCLES = TEST_PERIOD_CYC,
    parameter int unsigned SLOT_CYCLES = SLOT_CYC,
    parameter int unsigned DROP_CYCLES = DROP_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic ACT_OK_I,
    input wire logic ACT_WRONG_I,
    input wire logic ACT_EDGE_I,
    input wire logic TEACH_I,
    input wire logic [1:0] SAFE_IN_I,
    input wire logic FEEDBACK_MONITOR_INPUT_I,
    input wire logic START_MODE_I,
    input wire sosc_fault_t FAULT_I,
    output logic [1:0] SELF_TESTED_SAFETY_OUTPUT_O,
    output sosc_led_t LED_O,
    output logic DIAG_O,
    output logic READY_O
);

    // ----------------------------------------------------------------
    // Readiness delay after reset
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] rdy_cnt_q;
    logic ready_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdy_cnt_q <= '0;
            ready_q <= 1'b0;
        end else if (!ready_q) begin
            rdy_cnt_q <= rdy_cnt_q + 1'b1;
            if (rdy_cnt_q >= CNT_W'(READY_CYCLES - 1)) ready_q <= 1'b1; // RQ23
        end
    end

    // ----------------------------------------------------------------
    // Input glitch filter: a low only counts once it outlasts the window.
    // ----------------------------------------------------------------
    logic [1:0] in_ok_q;
    for (genvar g = 0; g < 2; g++) begin : g_filt
        logic [CNT_W-1:0] low_cnt_q;
        always_ff @(posedge CLK_I or posedge RST_I) begin
            if (RST_I) begin
                low_cnt_q <= '0;
                in_ok_q[g] <= 1'b0;
            end else if (SAFE_IN_I[g]) begin
                low_cnt_q <= '0;
                in_ok_q[g] <= 1'b1;
            end else if (low_cnt_q < CNT_W'(GLITCH_CYCLES)) begin
                low_cnt_q <= low_cnt_q + 1'b1;
            end else begin
                in_ok_q[g] <= 1'b0; // RQ7
            end
        end
    end
    wire inputs_ok = &in_ok_q;

    // ----------------------------------------------------------------
    // Start pulse measurement
    // ----------------------------------------------------------------
    logic fb_prev_q;
    logic [CNT_W-1:0] pw_cnt_q;
    logic start_seen_q;
    logic start_bad_q;
    logic state_on;
    logic arm;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            // The unused feedback input idles high, so this avoids a false edge after reset.
            fb_prev_q <= 1'b1;
            pw_cnt_q <= '0;
            start_seen_q <= 1'b0;
            start_bad_q <= 1'b0;
        end else begin
            fb_prev_q <= FEEDBACK_MONITOR_INPUT_I;
            if (FEEDBACK_MONITOR_INPUT_I && pw_cnt_q != '1) pw_cnt_q <= pw_cnt_q + 1'b1;
            if (FEEDBACK_MONITOR_INPUT_I && !fb_prev_q) pw_cnt_q <= '0;
            if (!arm) begin
                start_seen_q <= 1'b0;
            end else if (START_MODE_I && fb_prev_q && !FEEDBACK_MONITOR_INPUT_I) begin
                // Width is the count since the rising edge plus this cycle.
                if (pw_cnt_q + 1 >= CNT_W'(START_MIN_CYCLES)
                    && pw_cnt_q + 1 <= CNT_W'(START_MAX_CYCLES)) begin
                    start_seen_q <= 1'b1; // RQ12
                end else begin
                    start_bad_q <= 1'b1;
                end
            end
        end
    end
    // Automatic variant: the guard contacts simply read high when correct.
    wire fb_ok = START_MODE_I ? start_seen_q : FEEDBACK_MONITOR_INPUT_I; // RQ11
    wire any_fault = |FAULT_I || (start_bad_q && START_MODE_I);

    // ----------------------------------------------------------------
    // State machine
    // ----------------------------------------------------------------
    sosc_state_t st_q;
    sosc_state_t st_d;
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_INIT: if (ready_q) st_d = ST_IDLE; // RQ23
            ST_TEACH, ST_FAULT: st_d = st_q;
            default: begin
                if (any_fault || ACT_WRONG_I) st_d = ST_FAULT; // RQ2
                else if (TEACH_I) st_d = ST_TEACH;
                else if (!ACT_OK_I) st_d = ST_IDLE;
                else if (!inputs_ok) st_d = ST_INLOW;
                else if (!fb_ok) st_d = ST_WAITSTART;
                else st_d = ST_ON; // RQ1
            end
        endcase
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) st_q <= ST_INIT;
        else st_q <= st_d;
    end
    assign state_on = (st_q == ST_ON);
    assign arm = ACT_OK_I && inputs_ok && (st_q == ST_WAITSTART || st_q == ST_ON);

    // ----------------------------------------------------------------
    // Output self-test dropouts
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] tst_cnt_q;
    logic [1:0] out_q;
    logic hold_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            tst_cnt_q <= '0;
            hold_q <= 1'b0;
        end else begin
            tst_cnt_q <= (tst_cnt_q >= CNT_W'(TEST_CYCLES - 1)) ? '0 : tst_cnt_q + 1'b1;
            // Range-edge keeps whatever the outputs last were.
            if (!ACT_EDGE_I) hold_q <= state_on;
        end
    end
    // Dropout is the first DROP_CYCLES of each period, never longer.
    wire drop = tst_cnt_q < CNT_W'(DROP_CYCLES); // RQ3
    // Range edge keeps the last state, but a low input or a lost actuator still opens.
    wire edge_hold = hold_q && inputs_ok && ACT_OK_I; // RQ2
    wire at_edge = ACT_EDGE_I && st_q != ST_FAULT && st_q != ST_TEACH;
    wire out_en = at_edge ? edge_hold : state_on; // RQ17
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) out_q <= 2'h0;
        else out_q <= {2{out_en && !drop}}; // RQ5
    end
    assign SELF_TESTED_SAFETY_OUTPUT_O = out_q;

    // ----------------------------------------------------------------
    // Indicator patterns: six slots, blink 3/3, flash 1/5.
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] slot_cnt_q;
    logic [2:0] ph_q;
    logic [3:0] burst_q;
    logic [CNT_W-1:0] teach_cnt_q;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            slot_cnt_q <= '0;
            ph_q <= 3'h0;
            burst_q <= 4'h0;
        end else if (slot_cnt_q >= CNT_W'(SLOT_CYCLES - 1)) begin
            slot_cnt_q <= '0;
            ph_q <= (ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
            if (ph_q == 3'h5) burst_q <= (burst_q == 4'h9) ? 4'h0 : burst_q + 4'h1;
        end else begin
            slot_cnt_q <= slot_cnt_q + 1'b1;
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) teach_cnt_q <= '0;
        else if (st_q != ST_TEACH) teach_cnt_q <= '0;
        else if (teach_cnt_q < CNT_W'(TEACH_CYCLES)) teach_cnt_q <= teach_cnt_q + 1'b1; // RQ24
    end
    wire blink = ph_q < 3'h3; // RQ20
    wire flash = ph_q == 3'h0; // RQ20
    logic [2:0] cause_d;
    logic [2:0] cause_q;
    logic [2:0] npulse;
    always_comb begin
        if (FAULT_I.out_fault) cause_d = PULSES_OUT;
        else if (FAULT_I.in_fault) cause_d = PULSES_IN;
        else if (FAULT_I.fb_fault || start_bad_q) cause_d = PULSES_FB;
        else cause_d = PULSES_WRONG; // RQ21
    end
    // The cause is frozen on entry to the fault state, since the fault inputs may clear later.
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) cause_q <= PULSES_WRONG;
        else if (st_q != ST_FAULT) cause_q <= cause_d; // RQ21
    end
    always_comb begin
        npulse = (st_q == ST_TEACH) ? PULSES_TEACH : cause_q;
    end
    wire red_burst = blink && burst_q < {1'b0, npulse};
    wire teach_wait = teach_cnt_q < CNT_W'(TEACH_CYCLES);

    sosc_led_t led_d;
    logic diag_d;
    always_comb begin
        led_d = '0;
        diag_d = 1'b0;
        case (st_q)
            ST_INIT, ST_IDLE: led_d.yellow = 1'b1;
            ST_ON: begin
                led_d.green = 1'b1;
                diag_d = 1'b1; // RQ14
            end
            ST_INLOW: begin
                led_d.green = blink;
                diag_d = 1'b1; // RQ15
            end
            ST_WAITSTART: begin
                led_d.green = flash;
                diag_d = 1'b1; // RQ16
            end
            ST_TEACH: begin
                led_d.red = teach_wait && red_burst; // RQ22
                led_d.yellow = !teach_wait && flash; // RQ18
                diag_d = led_d.yellow; // RQ13
            end
            default: led_d.red = red_burst; // RQ19
        endcase
        if (ACT_EDGE_I && st_q != ST_FAULT && st_q != ST_TEACH && st_q != ST_INIT) begin
            led_d = '0;
            led_d.yellow = blink;
            diag_d = blink; // RQ17
        end
    end
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            LED_O <= '0;
            DIAG_O <= 1'b0;
            READY_O <= 1'b0;
        end else begin
            LED_O <= led_d;
            DIAG_O <= diag_d;
            READY_O <= ready_q;
        end
    end

endmodule : sosc_ctrl

// File: tb/safety_output_state_controller_test.sv
`timescale 1ns/1ps
module safety_output_state_controller_test;
    import sosc_pkg::*;
    localparam int RDY = 20, GL = 5, SMIN = 10, TCH = 30, TST = 40, SLOT = 4, DRP = 2;
    localparam int W = 120, ON = W - W / TST * DRP, BURST = 60 * SLOT;
    logic clk = 1'h0, rst = 1'h1, act_ok = 1'h0, act_wrong = 1'h0, act_edge = 1'h0;
    logic teach = 1'h0, fb = 1'h1, smode = 1'h0, up = 1'h1, pulse = 1'h0, rdy, diag, trip;
    logic [3:0] plen = 4'h0;
    logic [1:0] safe, so;
    logic [31:0] seed = 32'hEBED;
    sosc_fault_t fault = '0;
    sosc_led_t led;
    int failures = 0, samples_checked = 0, k;
    int n_so, n_g, n_r, n_y, n_d, n_t, n_m, low_run, max_low;
    int np[5] = '{1, 2, 3, 6, 6};
    sosc_ctrl #(.READY_CYCLES(RDY), .GLITCH_CYCLES(GL), .START_MIN_CYCLES(SMIN),
        .START_MAX_CYCLES(50), .TEACH_CYCLES(TCH), .TEST_CYCLES(TST), .SLOT_CYCLES(SLOT),
        .DROP_CYCLES(DRP)) sosc_ctrl_i (.CLK_I(clk), .RST_I(rst), .ACT_OK_I(act_ok),
        .ACT_WRONG_I(act_wrong), .ACT_EDGE_I(act_edge), .TEACH_I(teach), .SAFE_IN_I(safe),
        .FEEDBACK_MONITOR_INPUT_I(fb), .START_MODE_I(smode), .FAULT_I(fault),
        .SELF_TESTED_SAFETY_OUTPUT_O(so), .LED_O(led), .DIAG_O(diag), .READY_O(rdy));
    sosc_partner sosc_partner_i (.clk_i(clk), .rst_i(rst), .up_i(up), .pulse_i(pulse),
        .len_i(plen), .sto_i(so), .prev_o(safe), .trip_o(trip));
    initial forever #2.5 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic hold(input int n);
        repeat (n) @(negedge clk);
    endtask : hold
    task automatic chk(input string what, input int exp, input int got);
        samples_checked++;
        if (exp != got) begin
            failures++;
            $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
        end
    endtask : chk
    // Counting over whole pattern periods makes the figures independent of phase.
    task automatic expect5(input int n, e_so, e_g, e_r, e_y, e_d);
        {n_so, n_g, n_r, n_y, n_d, n_t, n_m, low_run, max_low} = '0;
        repeat (n) begin
            @(negedge clk);
            n_so += (so === 2'h3);
            n_g += (led.green === 1'h1);
            n_r += (led.red === 1'h1);
            n_y += (led.yellow === 1'h1);
            n_d += (diag === 1'h1);
            n_t += (trip === 1'h1);
            n_m += (diag !== led.yellow);
            low_run = (so === 2'h3) ? 0 : low_run + 1;
            max_low = (low_run > max_low) ? low_run : max_low;
        end
        if (e_so >= 0) chk("outputs", e_so, n_so);
        if (e_g >= 0) chk("green", e_g, n_g);
        if (e_r >= 0) chk("red", e_r, n_r);
        chk("yellow", e_y, n_y);
        chk("diag", e_d, n_d);
    endtask : expect5
    task automatic do_reset();
        rst = 1'h1;
        {act_ok, act_wrong, act_edge, teach, smode, fault} = '0;
        fb = 1'h1;
        hold(3);
        chk("reset outputs", 1, so === 2'h0 && diag === 1'h0);
        rst = 1'h0;
        hold(5);
        chk("idle before ready", 1, so === 2'h0 && rdy === 1'h0 && led === 3'h1);
        hold(RDY);
        chk("ready", 1, rdy === 1'h1);
        act_ok = 1'h1;
        hold(12);
    endtask : do_reset
    task automatic stop_test();
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : stop_test
    task automatic upstream_low(input int n);
        plen = 4'(n);
        pulse = 1'h1;
        hold(1);
        pulse = 1'h0;
    endtask : upstream_low
    initial begin
        hold(12000);
        failures++;
        stop_test();
    end
    initial begin
        do_reset();
        expect5(W, ON, W, 0, 0, W);
        chk("dropout", DRP, max_low);
        chk("downstream trips", 0, n_t);
        repeat (3) begin
            upstream_low(1 + rnd() % GL);
            expect5(W, ON, W, 0, 0, W);
        end
        upstream_low(GL + 3);
        expect5(W, -1, -1, 0, 0, W);
        chk("green mostly steady", 1, n_g >= W - 3);
        chk("long low trips", 1, max_low > DRP && n_t > 0 && n_so < ON);
        up = 1'h0;
        hold(12);
        expect5(W, 0, W / 2, 0, 0, W);
        up = 1'h1;
        act_ok = 1'h0;
        hold(12);
        expect5(W, 0, 0, 0, W, 0);
        act_ok = 1'h1;
        hold(12);
        act_edge = 1'h1;
        hold(12);
        expect5(W, -1, 0, 0, W / 2, W / 2);
        chk("diag tracks yellow", 0, n_m);
        chk("outputs held", 1, n_so >= ON);
        {act_edge, act_ok, fb} = 3'h0;
        smode = 1'h1;
        hold(3);
        act_ok = 1'h1;
        hold(12);
        expect5(W, 0, W / 6, 0, 0, W);
        fb = 1'h1;
        hold(SMIN + 1);
        fb = 1'h0;
        hold(12);
        expect5(W, ON, W, 0, 0, W);
        act_ok = 1'h0;
        hold(3);
        act_ok = 1'h1;
        hold(12);
        fb = 1'h1;
        hold(SMIN - 2);
        fb = 1'h0;
        hold(12);
        expect5(BURST, 0, 0, 3 * 3 * SLOT, 0, 0);
        k = rnd() % 5;
        for (int i = 0; i < 5; i++) begin
            do_reset();
            act_wrong = (k == 4);
            fault = (k == 4) ? '0 : sosc_fault_t'(4'h8 >> k);
            hold(3);
            expect5(BURST, 0, 0, np[k] * 3 * SLOT, 0, 0);
            k = (k + 1) % 5;
        end
        do_reset();
        teach = 1'h1;
        hold(TCH + 12);
        expect5(W, 0, 0, -1, W / 6, W / 6);
        chk("teach diag tracks yellow", 0, n_m);
        teach = 1'h0;
        expect5(W, 0, 0, -1, W / 6, W / 6);
        stop_test();
    end
endmodule : safety_output_state_controller_test

// File: tb/sosc_partner.sv
`timescale 1ns/1ps
module sosc_partner (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic up_i,
    input wire logic pulse_i,
    input wire logic [3:0] len_i,
    input wire logic [1:0] sto_i,
    output logic [1:0] prev_o,
    output logic trip_o
);
    logic [3:0] gap_q;
    logic [3:0] low_q;
    // The upstream sensor's own test dropouts reach our safety inputs as short lows.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gap_q <= 4'h0;
        end else begin
            gap_q <= pulse_i ? len_i : gap_q - 4'(gap_q != 4'h0);
        end
    end
    assign prev_o = (up_i && gap_q == 4'h0) ? 2'h3 : 2'h0;
    // The downstream controller reads only both outputs and adds no pulses of its own.
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            low_q <= 4'h0;
        end else begin
            low_q <= (sto_i == 2'h3) ? 4'h0 : low_q + 4'(low_q != 4'hF);
        end
    end
    assign trip_o = low_q > 4'h2;
endmodule : sosc_partner

// File: tb/sosc_props.sv
`timescale 1ns/1ps
module sosc_props
    import sosc_pkg::*;
#(
    parameter int unsigned READY_CYCLES = READY_CYC,
    parameter int unsigned GLITCH_CYCLES = GLITCH_CYC,
    parameter int unsigned DROP_CYCLES = DROP_CYC
) (
    input wire logic CLK_I,
    input wire logic RST_I,
    input wire logic ACT_OK_I,
    input wire logic ACT_WRONG_I,
    input wire logic ACT_EDGE_I,
    input wire logic TEACH_I,
    input wire logic [1:0] SAFE_IN_I,
    input wire logic FEEDBACK_MONITOR_INPUT_I,
    input wire logic START_MODE_I,
    input wire sosc_fault_t FAULT_I,
    input wire logic [1:0] SELF_TESTED_SAFETY_OUTPUT_O,
    input wire sosc_led_t LED_O,
    input wire logic DIAG_O,
    input wire logic READY_O
);
    logic [31:0] up_q;
    logic [31:0] low_q;
    logic [31:0] drop_q;
    logic lock_q;
    logic [1:0] so;
    logic ok;
    logic bad;
    assign so = SELF_TESTED_SAFETY_OUTPUT_O;
    assign bad = FAULT_I != 4'h0 || ACT_WRONG_I;
    assign ok = READY_O && !lock_q && ACT_OK_I && SAFE_IN_I == 2'h3 && FEEDBACK_MONITOR_INPUT_I
        && !START_MODE_I && !bad && !ACT_EDGE_I && !TEACH_I;
    always_ff @(posedge CLK_I or posedge RST_I) begin
        if (RST_I) begin
            up_q <= '0;
            low_q <= '0;
            drop_q <= '0;
            lock_q <= 1'b0;
        end else begin
            if (up_q != '1) up_q <= up_q + 32'h1;
            low_q <= (SAFE_IN_I == 2'h3) ? '0 : low_q + 32'(low_q != '1);
            drop_q <= (so == 2'h3) ? '0 : drop_q + 32'(drop_q != '1);
            // Fault, teach and start latches outlive their causes, so they end the good window.
            if ((bad || TEACH_I || START_MODE_I) && READY_O) lock_q <= 1'b1;
        end
    end
    default clocking @(posedge CLK_I); endclocking
    default disable iff (RST_I);
    // Eight good cycles clear both the answer latency and the input low filter.
    sequence s_good; ok [*8]; endsequence
    property p_ready; READY_O == (up_q > READY_CYCLES); endproperty
    a_ready: assert property (p_ready) else $error("ready too early");
    property p_pair; so[0] == so[1]; endproperty
    a_pair: assert property (p_pair) else $error("outputs differ");
    property p_act; (!ACT_OK_I) [*2] |=> so == 2'h0; endproperty
    a_act: assert property (p_act) else $error("on without actuator");
    property p_in; SAFE_IN_I != 2'h3 && low_q >= GLITCH_CYCLES |-> ##3 so == 2'h0; endproperty
    a_in: assert property (p_in) else $error("on with inputs low");
    property p_fault;
        bad && READY_O |-> ##3 (so == 2'h0 && !DIAG_O && !LED_O.green && !LED_O.yellow);
    endproperty
    a_fault: assert property (p_fault) else $error("fault not shown");
    property p_teach; TEACH_I && READY_O |-> ##3 (so == 2'h0 && !LED_O.green); endproperty
    a_teach: assert property (p_teach) else $error("teach not shown");
    property p_led; s_good |-> LED_O.green && DIAG_O && !LED_O.red && !LED_O.yellow; endproperty
    a_led: assert property (p_led) else $error("ready indication wrong");
    property p_drop; s_good |-> drop_q <= DROP_CYCLES; endproperty
    a_drop: assert property (p_drop) else $error("dropout too long");
endmodule : sosc_props
bind sosc_ctrl sosc_props #(
    .READY_CYCLES(READY_CYCLES),
    .GLITCH_CYCLES(GLITCH_CYCLES),
    .DROP_CYCLES(DROP_CYCLES)
) sosc_props_i (.*);
